// ---- dv/branch_jump_execution_tb.sv ----
module branch_jump_execution_tb;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg clkEn = 1'b1;
  reg start = 1'b0;
  reg sourceMode = 1'b0;
  reg internalExec = 1'b1;
  reg destExternal = 1'b0;
  reg testedBit = 1'b0;
  reg [3:0] opKind = 4'h0;
  reg [1:0] opForm = 2'h0;
  reg [1:0] operandSpace = 2'h0;
  reg [23:0] pcIn = 24'h000100;
  reg [23:0] farAddr = 24'h123456;
  reg [7:0] displacement = 8'hf1;
  reg [7:0] mainOperand = 8'h00;
  reg [7:0] firstOperand = 8'h03;
  reg [7:0] secondOperand = 8'h07;
  reg [7:0] countOperand = 8'h01;
  reg [10:0] pageAddr = 11'h124;
  reg [15:0] wideAddr = 16'h4321;
  reg [15:0] dataPointer = 16'hff02;
  wire ready, done, branchTaken, carryWrite, carryValue, bitWrite, bitValue, countWrite;
  wire [23:0] pcOut;
  wire [7:0] countResult;
  wire [2:0] instrLength;
  wire [4:0] stateCount;
  int errors = 0;
  int check_count = 0;
  branch_jump_execution i_branch_jump_execution (
    .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .start(start), .opKind(opKind), .opForm(opForm),
    .sourceMode(sourceMode), .operandSpace(operandSpace), .internalExec(internalExec),
    .destExternal(destExternal), .pcIn(pcIn), .displacement(displacement), .pageAddr(pageAddr),
    .wideAddr(wideAddr), .farAddr(farAddr), .mainOperand(mainOperand), .dataPointer(dataPointer),
    .testedBit(testedBit), .firstOperand(firstOperand), .secondOperand(secondOperand),
    .countOperand(countOperand), .ready(ready), .done(done), .pcOut(pcOut), .branchTaken(branchTaken),
    .carryWrite(carryWrite), .carryValue(carryValue), .bitWrite(bitWrite), .bitValue(bitValue),
    .countWrite(countWrite), .countResult(countResult), .instrLength(instrLength), .stateCount(stateCount)
  );
  always #2.5 clock = ~clock;
  task automatic final_report;
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One instruction; stall freezes the clock enable for that many edges
  task automatic run(input [3:0] k, input [1:0] f, input [1:0] sp, input sm, input [4:0] st,
      input [2:0] len, input tk, input int stall);
    int n;
    @(posedge clock);
    opKind <= k;
    opForm <= f;
    operandSpace <= sp;
    sourceMode <= sm;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    if (stall > 0) begin
      clkEn <= 1'b0;
      repeat (stall) @(posedge clock);
      clkEn <= 1'b1;
    end
    #1;
    `CHK("ready", 1'b0, ready)
    n = stall;
    while (done !== 1'b1) begin
      if (n > 40) begin
        errors++;
        final_report();
      end
      @(posedge clock);
      #1;
      n++;
    end
    `CHK("states", st, stateCount)
    `CHK("cycles", st + stall, n)
    `CHK("length", len, instrLength)
    `CHK("taken", tk, branchTaken)
    `CHK("ready", 1'b1, ready)
    // Return on a rising edge so the next operands are driven there
    @(posedge clock);
  endtask
  task automatic t_bits;
    testedBit <= 1'b1;
    run(4'h0, 2'h0, 2'h0, 1'b0, 5'h05, 3'h3, 1'b1, 0);
    `CHK("pc", 24'h0000f4, pcOut)
    run(4'h1, 2'h1, 2'h1, 1'b0, 5'h05, 3'h5, 1'b0, 0);
    testedBit <= 1'b0;
    run(4'h1, 2'h0, 2'h2, 1'b1, 5'h07, 3'h3, 1'b1, 0);
    run(4'h0, 2'h1, 2'h0, 1'b1, 5'h03, 3'h4, 1'b0, 0);
  endtask
  task automatic t_tcb;
    testedBit <= 1'b1;
    run(4'h2, 2'h0, 2'h2, 1'b0, 5'h0c, 3'h3, 1'b1, 0);
    `CHK("bitWrite", 1'b1, bitWrite)
    run(4'h2, 2'h1, 2'h0, 1'b0, 5'h0a, 3'h5, 1'b1, 0);
    `CHK("pc", 24'h0000f6, pcOut)
    testedBit <= 1'b0;
    run(4'h2, 2'h1, 2'h1, 1'b1, 5'h09, 3'h4, 1'b0, 0);
    `CHK("bitWrite", 1'b0, bitWrite)
  endtask
  task automatic t_acc;
    displacement <= 8'h03;
    run(4'h3, 2'h0, 2'h0, 1'b0, 5'h06, 3'h2, 1'b1, 0);
    `CHK("pc", 24'h000105, pcOut)
    internalExec <= 1'b0;
    run(4'h3, 2'h0, 2'h0, 1'b1, 5'h05, 3'h2, 1'b1, 0);
    run(4'h4, 2'h0, 2'h0, 1'b0, 5'h02, 3'h2, 1'b0, 0);
    `CHK("pc", 24'h000102, pcOut)
  endtask
  task automatic t_cmp;
    run(4'h5, 2'h0, 2'h2, 1'b0, 5'h07, 3'h3, 1'b1, 0);
    `CHK("carry", 1'b1, carryValue)
    firstOperand <= 8'h09;
    secondOperand <= 8'h09;
    run(4'h5, 2'h1, 2'h1, 1'b1, 5'h02, 3'h3, 1'b0, 0);
    `CHK("carry", 1'b0, carryValue)
    firstOperand <= 8'h08;
    secondOperand <= 8'h02;
    run(4'h5, 2'h2, 2'h0, 1'b1, 5'h06, 3'h4, 1'b1, 0);
    run(4'h5, 2'h3, 2'h0, 1'b0, 5'h06, 3'h3, 1'b1, 0);
    secondOperand <= 8'h09;
    run(4'h5, 2'h3, 2'h0, 1'b1, 5'h07, 3'h4, 1'b1, 0);
    `CHK("carry", 1'b1, carryValue)
  endtask
  task automatic t_cnt;
    run(4'h6, 2'h0, 2'h0, 1'b1, 5'h03, 3'h3, 1'b0, 0);
    `CHK("count", 8'h00, countResult)
    run(4'h6, 2'h1, 2'h2, 1'b0, 5'h06, 3'h3, 1'b0, 0);
    countOperand <= 8'h00;
    run(4'h6, 2'h0, 2'h0, 1'b0, 5'h05, 3'h2, 1'b1, 0);
    `CHK("count", 8'hff, countResult)
    countOperand <= 8'h05;
    run(4'h6, 2'h1, 2'h1, 1'b1, 5'h08, 3'h3, 1'b1, 0);
  endtask
  task automatic t_jmp;
    internalExec <= 1'b1;
    pcIn <= 24'h0007fe;
    run(4'h7, 2'h0, 2'h0, 1'b0, 5'h03, 3'h2, 1'b1, 0);
    `CHK("pc", 24'h000924, pcOut)
    destExternal <= 1'b1;
    run(4'h7, 2'h0, 2'h0, 1'b1, 5'h05, 3'h2, 1'b1, 0);
    run(4'h8, 2'h1, 2'h0, 1'b0, 5'h0a, 3'h3, 1'b1, 0);
    destExternal <= 1'b0;
    run(4'h8, 2'h0, 2'h0, 1'b1, 5'h05, 3'h4, 1'b1, 0);
    `CHK("pc", 24'h123456, pcOut)
    pcIn <= 24'h0a0000;
    run(4'h9, 2'h0, 2'h0, 1'b0, 5'h06, 3'h3, 1'b1, 0);
    `CHK("pc", 24'h0a4321, pcOut)
    run(4'h9, 2'h1, 2'h0, 1'b1, 5'h06, 3'h2, 1'b1, 0);
    pcIn <= 24'h000100;
    displacement <= 8'h80;
    run(4'ha, 2'h0, 2'h0, 1'b0, 5'h04, 3'h2, 1'b1, 3);
    `CHK("pc", 24'h000082, pcOut)
    mainOperand <= 8'hff;
    run(4'hb, 2'h0, 2'h0, 1'b0, 5'h06, 3'h1, 1'b1, 0);
    `CHK("pc", 24'hff0001, pcOut)
    pcIn <= 24'h0001ff;
    destExternal <= 1'b1;
    run(4'hc, 2'h0, 2'h0, 1'b1, 5'h01, 3'h1, 1'b0, 0);
    `CHK("pc", 24'h000200, pcOut)
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_bits();
    t_tcb();
    t_acc();
    t_cmp();
    t_cnt();
    t_jmp();
    final_report();
  end
endmodule // branch_jump_execution_tb

// ---- dv/branch_jump_props.sv ----
module branch_jump_props #(
  parameter PC_W = 24
) (
  input wire clock,
  input wire rst_n,
  input wire clkEn,
  input wire start,
  input wire [3:0] opKind,
  input wire [PC_W-1:0] pcIn,
  input wire [7:0] displacement,
  input wire [7:0] mainOperand,
  input wire testedBit,
  input wire [7:0] firstOperand,
  input wire [7:0] secondOperand,
  input wire [7:0] countOperand,
  input wire ready,
  input wire done,
  input wire [PC_W-1:0] pcOut,
  input wire branchTaken,
  input wire carryWrite,
  input wire carryValue,
  input wire bitWrite,
  input wire bitValue,
  input wire countWrite,
  input wire [7:0] countResult,
  input wire [2:0] instrLength,
  input wire [4:0] stateCount
);
  wire accept = clkEn && start && ready;
  wire [PC_W-1:0] relExt = {{(PC_W-8){displacement[7]}}, displacement};
  reg [4:0] edgeCnt_ff;
  // Enabled edges since the last accept
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      edgeCnt_ff <= 5'h00;
    else if (accept)
      edgeCnt_ff <= 5'h00;
    else if (clkEn && edgeCnt_ff != 5'h1f)
      edgeCnt_ff <= edgeCnt_ff + 5'h01;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_nop_result: assert property (
    accept && opKind == 4'hc |=> pcOut == $past(pcIn) + 1'b1 && stateCount == 5'h01 && !branchTaken)
    else $error("nop result wrong");
  a_near_target: assert property (
    accept && opKind == 4'ha |=> branchTaken && pcOut == $past(pcIn) + 2'h2 + $past(relExt))
    else $error("near jump target wrong");
  a_bit_fallthru: assert property (
    accept && opKind == 4'h0 && !testedBit |=> !branchTaken && pcOut == $past(pcIn) + instrLength)
    else $error("bit test fall through wrong");
  a_clear_bit: assert property (
    accept && opKind == 4'h2 |=> bitWrite == $past(testedBit) && branchTaken == $past(testedBit) && !bitValue)
    else $error("test clear write wrong");
  a_zero_test: assert property (
    accept && opKind == 4'h3 |=> branchTaken == ($past(mainOperand) == 8'h00) && instrLength == 3'h2)
    else $error("zero branch wrong");
  a_compare_carry: assert property (
    accept && opKind == 4'h5 |=> carryWrite && carryValue == ($past(firstOperand) < $past(secondOperand))
      && branchTaken == ($past(firstOperand) != $past(secondOperand)))
    else $error("compare carry or branch wrong");
  a_count_down: assert property (
    accept && opKind == 4'h6 |=> countWrite && countResult == $past(countOperand) - 8'h01
      && branchTaken == ($past(countOperand) != 8'h01))
    else $error("count down wrong");
  a_done_count: assert property (
    done |-> edgeCnt_ff == stateCount)
    else $error("done not after charged states");
  c_compare: cover property (accept && opKind == 4'h5);
  c_taken_done: cover property (done && branchTaken);
  c_long_run: cover property (done && stateCount > 5'h09);
endmodule // branch_jump_props

bind branch_jump_execution branch_jump_props #(.PC_W(PC_W)) i_branch_jump_props (
  .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .start(start), .opKind(opKind), .pcIn(pcIn),
  .displacement(displacement), .mainOperand(mainOperand), .testedBit(testedBit), .firstOperand(firstOperand),
  .secondOperand(secondOperand), .countOperand(countOperand), .ready(ready), .done(done), .pcOut(pcOut),
  .branchTaken(branchTaken), .carryWrite(carryWrite), .carryValue(carryValue), .bitWrite(bitWrite),
  .bitValue(bitValue), .countWrite(countWrite), .countResult(countResult), .instrLength(instrLength),
  .stateCount(stateCount)
);

// ---- shared/branch_jump_defines.vh ----
// How it works
// RULE1 - Bit tests advance PC then add displacement on matching bit; low form 3 bytes, 2/5.
// RULE2 - General bit tests: 5 bytes 4/7 binary, 4 bytes 3/6 source.
// RULE3 - Bit-clear branch low form: 3 bytes, 2/5 states, both modes.
// RULE4 - Test-clear-branch: bit 1 is cleared and branch taken; bit 0 untouched, not taken.
// RULE5 - Test-clear-branch: low 4/7; general 7/10 binary, 6/9 source.
// RULE6 - Zero/nonzero branches test accumulator; 2 bytes, 2/5 states.
// RULE7 - Compare branch sets carry when first below second; branches when unequal.
// RULE8 - Compare accumulator with direct byte or immediate: 3 bytes, 2/5 states.
// RULE9 - Compare immediate with bank register: 3 bytes 2/5 binary, 4 bytes 3/6 source.
// RULE10 - Compare immediate with indirect byte: 3 bytes 3/6 binary, 4 bytes 4/7 source.
// RULE11 - Count-down branch decrements operand; branches when result is nonzero.
// RULE12 - Count-down bank: 2 bytes 2/5 binary, 3 bytes 3/6 source; direct 3/6.
// RULE13 - Bit tests and compares add 1 state on a port, 2 on a peripheral register.
// RULE14 - Count-down on direct byte adds 2 states on a port, 3 on a peripheral.
// RULE15 - Test-clear-branch adds 3 states on a port, 5 on a peripheral register.
// RULE16 - Taken conditional branch to an internal odd address adds 1 state internally.
// RULE17 - Page jump: PC plus 2, low 11 bits replaced, 3 states; far replaces 24 bits.
// RULE18 - Wide jump replaces low 16 bits; direct 3 bytes 5 states; indirect 6/5.
// RULE19 - Near relative jump: PC plus 2 plus displacement; 2 bytes, 4 states.
// RULE20 - Table jump: PC bits 23:16 all ones, low 16 accumulator plus data pointer; 5 states.
// RULE21 - No-operation increments PC by one; 1 byte, 1 state.
// RULE22 - Jumps add 2 (page) or 3 states when external; internal odd destination adds 1.
`ifndef BRANCH_JUMP_DEFINES_VH
`define BRANCH_JUMP_DEFINES_VH

`define OP_BIT_SET 4'h0
`define OP_BIT_CLEAR 4'h1
`define OP_TEST_CLEAR 4'h2
`define OP_ZERO 4'h3
`define OP_NONZERO 4'h4
`define OP_COMPARE 4'h5
`define OP_COUNT_DOWN 4'h6
`define OP_PAGE 4'h7
`define OP_FAR 4'h8
`define OP_WIDE 4'h9
`define OP_NEAR 4'ha
`define OP_TABLE 4'hb
`define OP_NOP 4'hc

`define FORM_LOWBIT 2'h0
`define FORM_GENBIT 2'h1
`define FORM_CMP_DIRECT 2'h0
`define FORM_CMP_IMM 2'h1
`define FORM_CMP_BANK 2'h2
`define FORM_CMP_IND 2'h3
`define FORM_DJ_BANK 2'h0
`define FORM_DJ_DIRECT 2'h1
`define FORM_ADDR 2'h0
`define FORM_INDIRECT 2'h1

`define SPACE_MEM 2'h0
`define SPACE_PORT 2'h1
`define SPACE_PERIPH 2'h2

`define LEN_LOWBIT 3'h3
`define LEN_GENBIT_BIN 3'h5
`define LEN_GENBIT_SRC 3'h4
`define LEN_ACC 3'h2
`define LEN_CMP_ACC 3'h3
`define LEN_CMP_REG_BIN 3'h3
`define LEN_CMP_REG_SRC 3'h4
`define LEN_DJ_BANK_BIN 3'h2
`define LEN_DJ_BANK_SRC 3'h3
`define LEN_DJ_DIRECT 3'h3
`define LEN_PAGE 3'h2
`define LEN_FAR_BIN 3'h5
`define LEN_FAR_SRC 3'h4
`define LEN_FARIND_BIN 3'h3
`define LEN_FARIND_SRC 3'h2
`define LEN_WIDE 3'h3
`define LEN_WIDEIND_BIN 3'h3
`define LEN_WIDEIND_SRC 3'h2
`define LEN_NEAR 3'h2
`define LEN_TABLE 3'h1
`define LEN_NOP 3'h1

`define ST_BIT_LOW 5'h02
`define ST_BIT_GEN_BIN 5'h04
`define ST_BIT_GEN_SRC 5'h03
`define ST_TCB_LOW 5'h04
`define ST_TCB_GEN_BIN 5'h07
`define ST_TCB_GEN_SRC 5'h06
`define ST_ACC 5'h02
`define ST_CMP_ACC 5'h02
`define ST_CMP_BANK_BIN 5'h02
`define ST_CMP_BANK_SRC 5'h03
`define ST_CMP_IND_BIN 5'h03
`define ST_CMP_IND_SRC 5'h04
`define ST_DJ_BANK_BIN 5'h02
`define ST_DJ_BANK_SRC 5'h03
`define ST_DJ_DIRECT 5'h03
`define ST_PAGE 5'h03
`define ST_FAR_BIN 5'h06
`define ST_FAR_SRC 5'h05
`define ST_FARIND_BIN 5'h07
`define ST_FARIND_SRC 5'h06
`define ST_WIDE 5'h05
`define ST_WIDEIND_BIN 5'h06
`define ST_WIDEIND_SRC 5'h05
`define ST_NEAR 5'h04
`define ST_TABLE 5'h05
`define ST_NOP 5'h01
`define ST_TAKEN 5'h03

`define X_BIT_PORT 5'h01
`define X_BIT_PERIPH 5'h02
`define X_DJ_PORT 5'h02
`define X_DJ_PERIPH 5'h03
`define X_TCB_PORT 5'h03
`define X_TCB_PERIPH 5'h05
`define X_ODD 5'h01
`define X_EXT_PAGE 5'h02
`define X_EXT_OTHER 5'h03

`define TABLE_PAGE 8'hff
`define PAGE_BITS 11

`endif

// ---- verilog/branch_jump_execution.v ----
`include "branch_jump_defines.vh"

module branch_jump_execution #(
  parameter PC_W = 24
) (
  input wire clock,
  input wire rst_n,
  input wire clkEn,
  input wire start,
  input wire [3:0] opKind,
  input wire [1:0] opForm,
  input wire sourceMode,
  input wire [1:0] operandSpace,
  input wire internalExec,
  input wire destExternal,
  input wire [PC_W-1:0] pcIn,
  input wire [7:0] displacement,
  input wire [10:0] pageAddr,
  input wire [15:0] wideAddr,
  input wire [PC_W-1:0] farAddr,
  input wire [7:0] mainOperand,
  input wire [15:0] dataPointer,
  input wire testedBit,
  input wire [7:0] firstOperand,
  input wire [7:0] secondOperand,
  input wire [7:0] countOperand,
  output wire ready,
  output wire done,
  output wire [PC_W-1:0] pcOut,
  output wire branchTaken,
  output wire carryWrite,
  output wire carryValue,
  output wire bitWrite,
  output wire bitValue,
  output wire countWrite,
  output wire [7:0] countResult,
  output wire [2:0] instrLength,
  output wire [4:0] stateCount
);
  reg [PC_W-1:0] pcOut_ff;
  reg branchTaken_ff;
  reg carryWrite_ff;
  reg carryValue_ff;
  reg bitWrite_ff;
  reg bitValue_ff;
  reg countWrite_ff;
  reg [7:0] countResult_ff;
  reg [2:0] instrLength_ff;
  reg [4:0] stateCount_ff;

  reg [PC_W-1:0] nxt_pc;
  reg nxt_taken;
  reg nxt_carryWrite;
  reg nxt_carry;
  reg nxt_bitWrite;
  reg nxt_countWrite;
  reg [4:0] nxt_states;

  wire busy;
  wire accept;
  wire [2:0] len;
  wire [PC_W-1:0] pcAdv;
  wire [PC_W-1:0] pcRel;
  wire [7:0] decremented;
  wire oddInternal;

  function isConditional;
    input [3:0] op;
    begin
      isConditional = (op <= `OP_COUNT_DOWN);
    end
  endfunction

  function isBitTest;
    input [3:0] op;
    begin
      isBitTest = (op == `OP_BIT_SET) || (op == `OP_BIT_CLEAR);
    end
  endfunction

  // Instruction length per kind, form and opcode mode
  function [2:0] lengthOf;
    input [3:0] op;
    input [1:0] form;
    input src;
    begin
      case (op)
        `OP_BIT_SET, `OP_BIT_CLEAR, `OP_TEST_CLEAR: begin
          if (form == `FORM_LOWBIT)
            lengthOf = `LEN_LOWBIT;
          else
            lengthOf = src ? `LEN_GENBIT_SRC : `LEN_GENBIT_BIN;
        end
        `OP_ZERO, `OP_NONZERO: lengthOf = `LEN_ACC;
        `OP_COMPARE: begin
          if (form == `FORM_CMP_DIRECT || form == `FORM_CMP_IMM)
            lengthOf = `LEN_CMP_ACC;
          else
            lengthOf = src ? `LEN_CMP_REG_SRC : `LEN_CMP_REG_BIN;
        end
        `OP_COUNT_DOWN: begin
          if (form == `FORM_DJ_DIRECT)
            lengthOf = `LEN_DJ_DIRECT;
          else
            lengthOf = src ? `LEN_DJ_BANK_SRC : `LEN_DJ_BANK_BIN;
        end
        `OP_PAGE: lengthOf = `LEN_PAGE;
        `OP_FAR: begin
          if (form == `FORM_INDIRECT)
            lengthOf = src ? `LEN_FARIND_SRC : `LEN_FARIND_BIN;
          else
            lengthOf = src ? `LEN_FAR_SRC : `LEN_FAR_BIN;
        end
        `OP_WIDE: begin
          if (form == `FORM_INDIRECT)
            lengthOf = src ? `LEN_WIDEIND_SRC : `LEN_WIDEIND_BIN;
          else
            lengthOf = `LEN_WIDE;
        end
        `OP_NEAR: lengthOf = `LEN_NEAR;
        `OP_TABLE: lengthOf = `LEN_TABLE;
        default: lengthOf = `LEN_NOP;
      endcase
    end
  endfunction

  // Base states: not-taken memory-operand count for conditionals, internal even-destination count for jumps
  function [4:0] baseStatesOf;
    input [3:0] op;
    input [1:0] form;
    input src;
    begin
      case (op)
        `OP_BIT_SET, `OP_BIT_CLEAR: begin
          if (form == `FORM_LOWBIT)
            baseStatesOf = `ST_BIT_LOW; // RULE1 RULE3
          else
            baseStatesOf = src ? `ST_BIT_GEN_SRC : `ST_BIT_GEN_BIN; // RULE2
        end
        `OP_TEST_CLEAR: begin
          if (form == `FORM_LOWBIT)
            baseStatesOf = `ST_TCB_LOW; // RULE5
          else
            baseStatesOf = src ? `ST_TCB_GEN_SRC : `ST_TCB_GEN_BIN; // RULE5
        end
        `OP_ZERO, `OP_NONZERO: baseStatesOf = `ST_ACC; // RULE6
        `OP_COMPARE: begin
          case (form)
            `FORM_CMP_BANK: baseStatesOf = src ? `ST_CMP_BANK_SRC : `ST_CMP_BANK_BIN; // RULE9
            `FORM_CMP_IND: baseStatesOf = src ? `ST_CMP_IND_SRC : `ST_CMP_IND_BIN; // RULE10
            default: baseStatesOf = `ST_CMP_ACC; // RULE8
          endcase
        end
        `OP_COUNT_DOWN: begin
          if (form == `FORM_DJ_DIRECT)
            baseStatesOf = `ST_DJ_DIRECT; // RULE12
          else
            baseStatesOf = src ? `ST_DJ_BANK_SRC : `ST_DJ_BANK_BIN; // RULE12
        end
        `OP_PAGE: baseStatesOf = `ST_PAGE; // RULE17
        `OP_FAR: begin
          if (form == `FORM_INDIRECT)
            baseStatesOf = src ? `ST_FARIND_SRC : `ST_FARIND_BIN;
          else
            baseStatesOf = src ? `ST_FAR_SRC : `ST_FAR_BIN;
        end
        `OP_WIDE: begin
          if (form == `FORM_INDIRECT)
            baseStatesOf = src ? `ST_WIDEIND_SRC : `ST_WIDEIND_BIN; // RULE18
          else
            baseStatesOf = `ST_WIDE; // RULE18
        end
        `OP_NEAR: baseStatesOf = `ST_NEAR; // RULE19
        `OP_TABLE: baseStatesOf = `ST_TABLE; // RULE20
        default: baseStatesOf = `ST_NOP; // RULE21
      endcase
    end
  endfunction

  // Extra states for a port or peripheral register operand
  function [4:0] spaceExtraOf;
    input [3:0] op;
    input [1:0] form;
    input [1:0] space;
    reg port;
    reg periph;
    begin
      port = (space == `SPACE_PORT);
      periph = (space == `SPACE_PERIPH);
      spaceExtraOf = 5'h00;
      if (isBitTest(op) || (op == `OP_COMPARE && form == `FORM_CMP_DIRECT)) begin
        if (port)
          spaceExtraOf = `X_BIT_PORT; // RULE13
        else if (periph)
          spaceExtraOf = `X_BIT_PERIPH; // RULE13
      end else if (op == `OP_COUNT_DOWN && form == `FORM_DJ_DIRECT) begin
        if (port)
          spaceExtraOf = `X_DJ_PORT; // RULE14
        else if (periph)
          spaceExtraOf = `X_DJ_PERIPH; // RULE14
      end else if (op == `OP_TEST_CLEAR) begin
        if (port)
          spaceExtraOf = `X_TCB_PORT; // RULE15
        else if (periph)
          spaceExtraOf = `X_TCB_PERIPH; // RULE15
      end
    end
  endfunction

  assign accept = start && !busy;
  assign len = lengthOf(opKind, opForm, sourceMode);
  // Advance by the instruction length first, then apply the displacement
  assign pcAdv = pcIn + {{(PC_W-3){1'b0}}, len}; // RULE1 RULE19 RULE21
  assign pcRel = pcAdv + {{(PC_W-8){displacement[7]}}, displacement}; // RULE19
  assign decremented = countOperand - 8'h01; // RULE11

  // Branch decision, side effects and new program counter
  always @* begin
    nxt_taken = 1'b0;
    nxt_carryWrite = 1'b0;
    nxt_carry = 1'b0;
    nxt_bitWrite = 1'b0;
    nxt_countWrite = 1'b0;
    nxt_pc = pcAdv;
    case (opKind)
      `OP_BIT_SET: nxt_taken = testedBit; // RULE1
      `OP_BIT_CLEAR: nxt_taken = !testedBit; // RULE1
      `OP_TEST_CLEAR: begin
        nxt_taken = testedBit; // RULE4
        nxt_bitWrite = testedBit; // RULE4
      end
      `OP_ZERO: nxt_taken = (mainOperand == 8'h00); // RULE6
      `OP_NONZERO: nxt_taken = (mainOperand != 8'h00); // RULE6
      `OP_COMPARE: begin
        nxt_carryWrite = 1'b1;
        nxt_carry = (firstOperand < secondOperand); // RULE7
        nxt_taken = (firstOperand != secondOperand); // RULE7
      end
      `OP_COUNT_DOWN: begin
        nxt_countWrite = 1'b1; // RULE11
        nxt_taken = (decremented != 8'h00); // RULE11
      end
      `OP_PAGE: begin
        nxt_taken = 1'b1;
        nxt_pc = {pcAdv[PC_W-1:`PAGE_BITS], pageAddr}; // RULE17
      end
      `OP_FAR: begin
        nxt_taken = 1'b1;
        nxt_pc = farAddr; // RULE17
      end
      `OP_WIDE: begin
        nxt_taken = 1'b1;
        nxt_pc = {pcAdv[PC_W-1:16], wideAddr}; // RULE18
      end
      `OP_NEAR: begin
        nxt_taken = 1'b1;
        nxt_pc = pcRel; // RULE19
      end
      `OP_TABLE: begin
        nxt_taken = 1'b1;
        nxt_pc = {`TABLE_PAGE, mainOperand + dataPointer}; // RULE20
      end
      default: nxt_taken = 1'b0; // RULE21
    endcase
    if (isConditional(opKind) && nxt_taken)
      nxt_pc = pcRel;
  end

  assign oddInternal = internalExec && !destExternal && nxt_pc[0];

  // State count with taken, space, external and odd-destination additions
  always @* begin
    nxt_states = baseStatesOf(opKind, opForm, sourceMode) + spaceExtraOf(opKind, opForm, operandSpace);
    if (isConditional(opKind)) begin
      if (nxt_taken) begin
        nxt_states = nxt_states + `ST_TAKEN;
        if (oddInternal)
          nxt_states = nxt_states + `X_ODD; // RULE16
      end
    end else if (opKind != `OP_NOP) begin
      if (destExternal)
        nxt_states = nxt_states + ((opKind == `OP_PAGE) ? `X_EXT_PAGE : `X_EXT_OTHER); // RULE22
      else if (oddInternal)
        nxt_states = nxt_states + `X_ODD; // RULE22
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pcOut_ff <= {PC_W{1'b0}};
      branchTaken_ff <= 1'b0;
      carryWrite_ff <= 1'b0;
      carryValue_ff <= 1'b0;
      bitWrite_ff <= 1'b0;
      bitValue_ff <= 1'b0;
      countWrite_ff <= 1'b0;
      countResult_ff <= 8'h00;
      instrLength_ff <= 3'h0;
      stateCount_ff <= 5'h00;
    end else if (clkEn && accept) begin
      pcOut_ff <= nxt_pc;
      branchTaken_ff <= nxt_taken;
      carryWrite_ff <= nxt_carryWrite;
      carryValue_ff <= nxt_carry;
      bitWrite_ff <= nxt_bitWrite;
      bitValue_ff <= 1'b0; // RULE4
      countWrite_ff <= nxt_countWrite;
      countResult_ff <= decremented;
      instrLength_ff <= len;
      stateCount_ff <= nxt_states;
    end
  end

  state_counter #(
    .CNT_W(5)
  ) stateTimer (
    .clock(clock),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .load(accept),
    .loadValue(nxt_states),
    .busy(busy),
    .finish(done)
  );

  assign ready = !busy;
  assign pcOut = pcOut_ff;
  assign branchTaken = branchTaken_ff;
  assign carryWrite = carryWrite_ff;
  assign carryValue = carryValue_ff;
  assign bitWrite = bitWrite_ff;
  assign bitValue = bitValue_ff;
  assign countWrite = countWrite_ff;
  assign countResult = countResult_ff;
  assign instrLength = instrLength_ff;
  assign stateCount = stateCount_ff;
endmodule // branch_jump_execution

// ---- verilog/state_counter.v ----
`include "branch_jump_defines.vh"

module state_counter #(
  parameter CNT_W = 5
) (
  input wire clock,
  input wire rst_n,
  input wire clkEn,
  input wire load,
  input wire [CNT_W-1:0] loadValue,
  output wire busy,
  output wire finish
);
  localparam S_IDLE = 2'b01;
  localparam S_COUNT = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [CNT_W-1:0] count_ff;
  reg [CNT_W-1:0] nxt_count;
  reg finish_ff;
  reg nxt_finish;

  // One state per clock; finish pulses the cycle after the last state
  always @* begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_finish = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (load) begin
          nxt_state = S_COUNT;
          nxt_count = loadValue;
        end
      end
      S_COUNT: begin
        if (count_ff <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          nxt_state = S_IDLE;
          nxt_finish = 1'b1;
          nxt_count = {CNT_W{1'b0}};
        end else begin
          nxt_count = count_ff - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        nxt_state = S_IDLE;
        nxt_count = {CNT_W{1'b0}};
      end
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      count_ff <= {CNT_W{1'b0}};
      finish_ff <= 1'b0;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      finish_ff <= nxt_finish;
    end
  end

  assign busy = state_ff[1];
  assign finish = finish_ff;
endmodule // state_counter
